// file: core/tcc_pkg.sv
// package for the triple comparator control block
// assumes a classic wishbone slave with 32-bit data, byte addresses
package tcc_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [3:0] TCC_CTRL1_OFS   = 4'h0;
   localparam logic [3:0] TCC_CTRL2_OFS   = 4'h4;
   localparam logic [3:0] TCC_CTRL3_OFS   = 4'h8;
   localparam logic [3:0] TCC_RESULT_OFS  = 4'hC;
   localparam logic [5:0] TCC_FLAG_OFS    = 6'h10;
   localparam logic [5:0] TCC_MASK_OFS    = 6'h14;
   localparam int         TCC_ADDR_W      = 6;
   // ==========================================================
   // field positions and reset values
   localparam int         TCC_ON_BIT      = 7;
   localparam int         TCC_PINOE_BIT   = 6;
   localparam int         TCC_INV_BIT     = 5;
   localparam int         TCC_REF_BIT     = 2;
   localparam int         TCC_RES_LSB     = 5;
   localparam logic [7:0] TCC_CTRL_RST    = 8'h1F;
   localparam logic [2:0] TCC_RESULT_RST  = 3'h7;
   localparam logic [2:0] TCC_FLAG_RST    = 3'h0;
   localparam logic [2:0] TCC_MASK_RST    = 3'h0;
   localparam int         TCC_NCH         = 3;

   typedef enum logic [1:0] {
      TCC_EV_OFF  = 2'b00,
      TCC_EV_RISE = 2'b01,
      TCC_EV_FALL = 2'b10,
      TCC_EV_ANY  = 2'b11
   } tcc_edge_type;

   typedef enum logic [1:0] {
      TCC_NEG_SECOND = 2'b00,
      TCC_NEG_THIRD  = 2'b01,
      TCC_NEG_SHARED = 2'b10,
      TCC_NEG_BANDGP = 2'b11
   } tcc_neg_type;

   typedef struct packed {
      logic         comparator_on;
      logic         pin_output_enable;
      logic         output_invert;
      tcc_edge_type event_edge_select;
      logic         positive_ref_select;
      tcc_neg_type  negative_channel_select;
   } tcc_ctrl_type;

   // analog mux selects for one channel
   typedef struct packed {
      logic       enable;
      logic       pos_ladder;
      logic [3:0] neg_onehot; // {bandgap, shared/alt, third, second}
   } tcc_mux_type;
endpackage

// file: core/tcc_top.sv
// control and status logic for three analog comparators
// assumes raw compare results arrive asynchronously from the analog cores
`timescale 1ns/1ps
// Function
// - three channels, each own control register
// - comparator_on bit enables the comparator
// - pin_output_enable routes result to pin
// - output_invert inverts pin, status and events
// - event_edge_select picks any, fall, rise, none
// - selecting any-change sets the event flag
// - positive_ref_select picks ladder or pin input
// - negative_channel_select drives inverting input mux
// - code 10: channel 2 uses alternate input
// - small package lacks some inputs; blocked
// - reset control to 1F, results to 1
// - results in bits 7-5, read-only
// - result bit reflects polarity-adjusted comparison
// - raw output high when VIN+ exceeds VIN-
// - flags bits 2-0; write one sets
// - flags set regardless of interrupt mask
// - port direction bit still enables pin
module tcc_top
   import tcc_pkg::*;
#(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [TCC_ADDR_W-1:0]   wb_adr_i,
   input  wire logic [31:0]             wb_dat_i,
   input  wire logic [3:0]              wb_sel_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // analog cores
   input  wire logic [TCC_NCH-1:0]      raw_result_i,
   output tcc_mux_type [TCC_NCH-1:0]    mux_sel_o,
   // pins
   input  wire logic [TCC_NCH-1:0]      port_dir_out_i,
   output logic      [TCC_NCH-1:0]      compare_output_pin_o,
   output logic      [TCC_NCH-1:0]      compare_output_pin_oe_o,
   // interrupt
   output logic                         irq_o
);
   // ==========================================================
   // functions
   function automatic logic is_addr(input logic [TCC_ADDR_W-1:0] a, input logic [TCC_ADDR_W-1:0] ofs);
      is_addr = (a[TCC_ADDR_W-1:2] == ofs[TCC_ADDR_W-1:2]);
   endfunction

   // mask unavailable input codes in the small package
   function automatic logic code_allowed(input int ch, input logic [1:0] code);
      code_allowed = 1'b1;
      if (SMALL_PACKAGE) begin
         if (code == TCC_NEG_THIRD && ch != 2)
            code_allowed = 1'b0;
         if (code == TCC_NEG_SHARED && ch == 1)
            code_allowed = 1'b0;
      end
   endfunction

   // ==========================================================
   // registers
   tcc_ctrl_type [TCC_NCH-1:0] ctrl_q;
   logic [TCC_NCH-1:0]         sync1_q;
   logic [TCC_NCH-1:0]         sync2_q;
   logic [TCC_NCH-1:0]         result_q;
   logic [TCC_NCH-1:0]         result_valid_q;
   logic [TCC_NCH-1:0]         flag_q;
   logic [TCC_NCH-1:0]         mask_q;
   logic [TCC_NCH-1:0]         event_d;
   logic [TCC_NCH-1:0]         adj_d;
   logic                       ack_q;
   logic [31:0]                rdata_q;
   logic                       req;
   logic                       wr;
   logic                       wr_lane0;

   assign req      = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr       = req && wb_we_i;
   assign wr_lane0 = wr && wb_sel_i[0];

   // ==========================================================
   // bus slave: one wait cycle, ack for every address
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ack_q <= 1'b0;
      else
         ack_q <= req;
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         rdata_q <= 32'h0000_0000;
         if (is_addr(wb_adr_i, {2'b00, TCC_CTRL1_OFS}))
            rdata_q[7:0] <= ctrl_q[0];
         else if (is_addr(wb_adr_i, {2'b00, TCC_CTRL2_OFS}))
            rdata_q[7:0] <= ctrl_q[1];
         else if (is_addr(wb_adr_i, {2'b00, TCC_CTRL3_OFS}))
            rdata_q[7:0] <= ctrl_q[2];
         else if (is_addr(wb_adr_i, {2'b00, TCC_RESULT_OFS}))
            rdata_q[7:TCC_RES_LSB] <= result_q;
         else if (is_addr(wb_adr_i, TCC_FLAG_OFS))
            rdata_q[2:0] <= flag_q;
         else if (is_addr(wb_adr_i, TCC_MASK_OFS))
            rdata_q[2:0] <= mask_q;
      end
   end

   // ==========================================================
   // control registers, one per channel
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= {TCC_NCH{TCC_CTRL_RST}};
      end else if (wr_lane0) begin
         if (is_addr(wb_adr_i, {2'b00, TCC_CTRL1_OFS}))
            ctrl_q[0] <= wb_dat_i[7:0];
         if (is_addr(wb_adr_i, {2'b00, TCC_CTRL2_OFS}))
            ctrl_q[1] <= wb_dat_i[7:0];
         if (is_addr(wb_adr_i, {2'b00, TCC_CTRL3_OFS}))
            ctrl_q[2] <= wb_dat_i[7:0];
      end
   end

   // ==========================================================
   // result path: sync, polarity, edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_result_i;
         sync2_q <= sync1_q;
      end
   end

   always_comb begin
      for (int i = 0; i < TCC_NCH; i++) begin
         // raw high means VIN+ above VIN-; a disabled comparator reads as its output_invert bit
         adj_d[i] = (ctrl_q[i].comparator_on & sync2_q[i]) ^ ctrl_q[i].output_invert;
      end
   end

   // result reset to one; first sample after reset seeds the edge history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q       <= TCC_RESULT_RST;
         result_valid_q <= '0;
      end else begin
         result_q       <= adj_d;
         result_valid_q <= '1;
      end
   end

   always_comb begin
      for (int i = 0; i < TCC_NCH; i++) begin
         event_d[i] = 1'b0;
         if (result_valid_q[i]) begin
            case (ctrl_q[i].event_edge_select)
               TCC_EV_RISE: event_d[i] = adj_d[i] & ~result_q[i];
               TCC_EV_FALL: event_d[i] = ~adj_d[i] & result_q[i];
               TCC_EV_ANY:  event_d[i] = adj_d[i] ^ result_q[i];
               default:     event_d[i] = 1'b0;
            endcase
         end
      end
   end

   // ==========================================================
   // event flags: set wins over clear; write one also sets
   logic [TCC_NCH-1:0] any_sel;
   always_comb begin
      for (int i = 0; i < TCC_NCH; i++) begin
         // every control write that selects any-change mode raises the flag
         any_sel[i] = wr_lane0 && is_addr(wb_adr_i, 6'(4 * i))
                      && (wb_dat_i[4:3] == TCC_EV_ANY);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= TCC_FLAG_RST;
      end else begin
         for (int i = 0; i < TCC_NCH; i++) begin
            if (event_d[i] || any_sel[i])
               flag_q[i] <= 1'b1;
            else if (wr_lane0 && is_addr(wb_adr_i, TCC_FLAG_OFS))
               flag_q[i] <= wb_dat_i[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         mask_q <= TCC_MASK_RST;
      else if (wr_lane0 && is_addr(wb_adr_i, TCC_MASK_OFS))
         mask_q <= wb_dat_i[2:0];
   end

   assign irq_o = |(flag_q & mask_q);

   // ==========================================================
   // analog mux selects and pins
   always_comb begin
      for (int i = 0; i < TCC_NCH; i++) begin
         mux_sel_o[i].enable     = ctrl_q[i].comparator_on;
         mux_sel_o[i].pos_ladder = ctrl_q[i].positive_ref_select;
         mux_sel_o[i].neg_onehot = 4'h0;
         // code 10 on channel 2 means the alternate input: the mux wires it
         if (code_allowed(i, ctrl_q[i].negative_channel_select))
            mux_sel_o[i].neg_onehot[ctrl_q[i].negative_channel_select] = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_output_pin_o    <= '0;
         compare_output_pin_oe_o <= '0;
      end else begin
         for (int i = 0; i < TCC_NCH; i++) begin
            compare_output_pin_o[i]    <= adj_d[i];
            compare_output_pin_oe_o[i] <= ctrl_q[i].pin_output_enable & port_dir_out_i[i];
         end
      end
   end
endmodule

// file: verif/tcc_checker.sv
// assertion checker for the comparator control block
// assumes it is bound to tcc_top and sees only its ports
`timescale 1ns/1ps
module tcc_checker
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   // wishbone slave
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [TCC_ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   // mux, pins, interrupt
   input wire tcc_mux_type [TCC_NCH-1:0] mux_sel_o,
   input wire logic [TCC_NCH-1:0]   port_dir_out_i,
   input wire logic [TCC_NCH-1:0]   compare_output_pin_oe_o,
   input wire logic                 irq_o
);
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_rd; wb_ack_o && !wb_we_i; endsequence
   property p_ack; s_req |=> wb_ack_o; endproperty
   property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_hi; s_rd |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
   property p_res; s_rd ##0 wb_adr_i[5:2] == 4'h3 |-> wb_dat_o[4:0] == 5'h00; endproperty
   property p_unm; s_rd ##0 wb_adr_i[5] |-> wb_dat_o == 32'h0000_0000; endproperty
   property p_oe; 1'b1 |=> (compare_output_pin_oe_o & ~$past(port_dir_out_i)) == 3'h0; endproperty
   property p_hot;
      $onehot0(mux_sel_o[0].neg_onehot) && $onehot0(mux_sel_o[1].neg_onehot) && $onehot0(mux_sel_o[2].neg_onehot);
   endproperty
   // selects only move on a taken write, so stray updates are caught
   property p_mux; !$stable(mux_sel_o) |-> wb_ack_o && wb_we_i; endproperty
   property p_irq; $fell(irq_o) |-> wb_ack_o && wb_we_i; endproperty
   a_ack: assert property (p_ack) else $error("no ack one cycle after request");
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   a_hi: assert property (p_hi) else $error("upper read bits not zero");
   a_res: assert property (p_res) else $error("result bits 4-0 not zero");
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   a_oe: assert property (p_oe) else $error("pin enabled without direction bit");
   a_hot: assert property (p_hot) else $error("inverting select not one-hot");
   a_mux: assert property (p_mux) else $error("mux select changed without write");
   a_irq: assert property (p_irq) else $error("irq fell without write");
endmodule
bind tcc_top tcc_checker chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mux_sel_o(mux_sel_o),
   .port_dir_out_i(port_dir_out_i), .compare_output_pin_oe_o(compare_output_pin_oe_o), .irq_o(irq_o));

// file: verif/tcc_analog_model.sv
// behavioural model of the three comparator cores and input muxes
// assumes levels come from the bench as small unsigned numbers
`timescale 1ns/1ps
module tcc_analog_model
   import tcc_pkg::*;
(
   // clock
   input  wire logic                    clk_i,
   // levels: [5] positive pin, [4] ladder, [3:0] inverting sources by code
   input  wire logic [5:0][3:0]         lvl_i,
   // selects in, raw results out
   input  wire tcc_mux_type [2:0]       mux_sel_i,
   output logic      [2:0]              raw_result_o
);
   logic tgl_q = 1'b0;
   always_ff @(posedge clk_i) tgl_q <= ~tgl_q;
   // an unselected inverting input floats: toggle rather than hold
   function automatic logic cmp(tcc_mux_type m, int c);
      int vp;
      int vn;
      vp = m.pos_ladder ? int'(lvl_i[4]) : int'(lvl_i[5]) + c;
      vn = -1;
      for (int k = 0; k < 4; k++)
         if (m.neg_onehot[k]) vn = int'(lvl_i[k]);
      if (vn < 0) return tgl_q;
      return vp > vn;
   endfunction
   always_comb
      for (int c = 0; c < 3; c++) raw_result_o[c] = cmp(mux_sel_i[c], c);
endmodule

// file: verif/triple_comparator_control_tb.sv
// self-checking bench for the comparator control block
// assumes tcc_top at full package size with the analog model on its far side,
// plus a small-package copy on the same bus whose input selects are checked
`timescale 1ns/1ps
module triple_comparator_control_tb;
   import tcc_pkg::*;
   logic            clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [5:0]      adr = 6'h00;
   logic [31:0]     wdat = 32'h0000_0000, rdat, dat_o;
   logic            ack, irq;
   logic [2:0]      raw, pin, oe, dir = 3'h7;
   logic [3:0]      sel = 4'h0;
   logic [5:0][3:0] lvl = '0;
   tcc_mux_type [2:0] mux, mux_s;
   int              error_cnt = 0, num_checks = 0, cyc_cnt = 0, seed = 21943;
   int              ctl[3], adj[3], flg, ex, e, a0;
   initial forever #5 clk_i = ~clk_i;
   tcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .raw_result_i(raw), .mux_sel_o(mux),
      .port_dir_out_i(dir), .compare_output_pin_o(pin), .compare_output_pin_oe_o(oe), .irq_o(irq));
   // small package copy: only its input selects are compared
   tcc_top #(.SMALL_PACKAGE(1'b1)) uut_small (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(), .wb_ack_o(),
      .raw_result_i(raw), .mux_sel_o(mux_s), .port_dir_out_i(dir), .compare_output_pin_o(),
      .compare_output_pin_oe_o(), .irq_o());
   tcc_analog_model ana (.clk_i(clk_i), .lvl_i(lvl), .mux_sel_i(mux), .raw_result_o(raw));
   // ==========================================================
   // report and bus tasks
   task end_sim;
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt = error_cnt + 1;
         end_sim;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
   endtask
   function automatic int exp_adj(int c);
      int vp;
      int vn;
      vp = ctl[c][2] ? lvl[4] : lvl[5] + c;
      vn = lvl[ctl[c] & 3];
      return (ctl[c][7] && vp > vn) ^ ctl[c][5];
   endfunction
   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int c = 0; c < 3; c++) begin
         wb(0, 6'(4 * c), 0);
         chk(rdat, 32'h0000_001F);
      end
      wb(1, 6'h24, 32'h0000_00FF);
      wb(0, 6'h24, 0);
      for (int i = 0; i < 40; i++) begin
         for (int c = 0; c < 3; c++) begin
            ctl[c] = $random(seed) & 8'hFF;
            wb(1, 6'(4 * c), ctl[c]);
            wb(0, 6'(4 * c), 0);
            chk(rdat, ctl[c]);
            chk(32'(mux[c]), 32'({ctl[c][7], ctl[c][2], 4'(1 << (ctl[c] & 3))}));
            e = ctl[c] & 3;
            chk(32'(mux_s[c].neg_onehot), ((e == 1 && c != 2) || (e == 2 && c == 1)) ? 0 : 1 << e);
         end
         lvl <= 24'($random(seed));
         dir <= 3'($random(seed));
         repeat (5) @(posedge clk_i);
         wb(0, 6'h10, 0);
         flg = 0;
         for (int c = 0; c < 3; c++)
            if (ctl[c][4:3] == 3) flg |= 1 << c;
         chk(rdat & flg, flg);
         wb(1, 6'h10, 0);
         // results are read-only: this write must leave them alone
         wb(1, 6'h0C, 32'h0000_00FF);
         wb(0, 6'h0C, 0);
         for (int c = 0; c < 3; c++) adj[c] = exp_adj(c);
         ex = adj[0] | adj[1] << 1 | adj[2] << 2;
         chk(rdat, ex << 5);
         chk(32'(pin), ex);
         chk(32'(oe), (ctl[0][6] | ctl[1][6] << 1 | ctl[2][6] << 2) & dir);
         lvl <= 24'($random(seed));
         repeat (5) @(posedge clk_i);
         flg = 0;
         for (int c = 0; c < 3; c++) begin
            a0 = adj[c];
            adj[c] = exp_adj(c);
            e = ctl[c][4:3];
            if ((e == 3 && a0 != adj[c]) || (e == 1 && adj[c] > a0) || (e == 2 && adj[c] < a0)) flg |= 1 << c;
         end
         wb(0, 6'h10, 0);
         chk(rdat, flg);
         a0 = $random(seed) & 7;
         e = $random(seed) & 7;
         wb(1, 6'h14, a0);
         wb(1, 6'h10, e);
         wb(0, 6'h10, 0);
         chk(rdat, e);
         chk(32'(irq), (e & a0) != 0);
      end
      end_sim;
   end
endmodule
